// >>> fdp_pkg.sv
package fdp_pkg;

   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int          FDP_AW        = 8;
   localparam int          FDP_DW        = 32;
   localparam int          FDP_ROM_WORDS = 16;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0]  FDP_OFF_SIG      = 8'h00;
   localparam logic [7:0]  FDP_OFF_REV      = 8'h04;
   localparam logic [7:0]  FDP_OFF_HDR      = 8'h08;
   localparam logic [7:0]  FDP_OFF_PTR      = 8'h0c;
   localparam logic [7:0]  FDP_OFF_ERASE    = 8'h30;
   localparam logic [7:0]  FDP_OFF_DENS     = 8'h34;
   localparam logic [7:0]  FDP_OFF_QUAD     = 8'h38;
   localparam logic [7:0]  FDP_OFF_DUAL     = 8'h3c;
   localparam logic [7:0]  FDP_OFF_ROM_END  = 8'h40;
   localparam logic [7:0]  FDP_OFF_STR_ADDR = 8'h40;
   localparam logic [7:0]  FDP_OFF_STR_DATA = 8'h44;

   // ----------------------------------------------------------------
   // Table fields
   // ----------------------------------------------------------------
   localparam logic [7:0]  FDP_SIG_B0       = 8'h53;
   localparam logic [7:0]  FDP_SIG_B1       = 8'h46;
   localparam logic [7:0]  FDP_SIG_B2       = 8'h44;
   localparam logic [7:0]  FDP_SIG_B3       = 8'h50;
   localparam logic [7:0]  FDP_REV_MINOR    = 8'h06;
   localparam logic [7:0]  FDP_REV_MAJOR    = 8'h01;
   localparam logic [7:0]  FDP_HEADER_COUNT = 8'h00;
   localparam logic [7:0]  FDP_FILL         = 8'hff;
   localparam logic [15:0] FDP_BASIC_ID     = 16'hff00;
   localparam logic [7:0]  FDP_TBL_LEN      = 8'h10;
   localparam logic [23:0] FDP_TABLE_PTR    = 24'h000030;
   localparam logic [1:0]  FDP_ERASE_SIZE   = 2'b01;
   localparam logic        FDP_WR_GRAN      = 1'b1;
   localparam logic        FDP_VOL_BP       = 1'b0;
   localparam logic        FDP_WREN_SEL     = 1'b0;
   localparam logic [2:0]  FDP_UNUSED3      = 3'b111;
   localparam logic [7:0]  FDP_ERASE4K_INS  = 8'h20;
   localparam logic        FDP_SUP_112      = 1'b1;
   localparam logic [1:0]  FDP_ADDR_BYTES   = 2'b01;
   localparam logic        FDP_SUP_DTR      = 1'b1;
   localparam logic        FDP_SUP_122      = 1'b1;
   localparam logic        FDP_SUP_144      = 1'b1;
   localparam logic        FDP_SUP_114      = 1'b1;
   localparam logic        FDP_UNUSED1      = 1'b1;
   localparam logic [31:0] FDP_DENSITY      = 32'h07ffffff;
   localparam logic [4:0]  FDP_WAIT_144     = 5'b00100;
   localparam logic [2:0]  FDP_MODE_144     = 3'b010;
   localparam logic [7:0]  FDP_INS_144      = 8'heb;
   localparam logic [4:0]  FDP_WAIT_114     = 5'b01000;
   localparam logic [2:0]  FDP_MODE_114     = 3'b000;
   localparam logic [7:0]  FDP_INS_114      = 8'h6b;
   localparam logic [4:0]  FDP_WAIT_112     = 5'b01000;
   localparam logic [2:0]  FDP_MODE_112     = 3'b000;
   localparam logic [7:0]  FDP_INS_112      = 8'h3b;
   localparam logic [4:0]  FDP_WAIT_122     = 5'b00000;
   localparam logic [2:0]  FDP_MODE_122     = 3'b100;
   localparam logic [7:0]  FDP_INS_122      = 8'hbb;

   // ----------------------------------------------------------------
   // Assembled table words, least significant byte at lowest address
   // ----------------------------------------------------------------
   localparam logic [31:0] FDP_WORD_SIG =
      {FDP_SIG_B3, FDP_SIG_B2, FDP_SIG_B1, FDP_SIG_B0};
   localparam logic [31:0] FDP_WORD_REV =
      {FDP_FILL, FDP_HEADER_COUNT, FDP_REV_MAJOR, FDP_REV_MINOR};
   localparam logic [31:0] FDP_WORD_HDR =
      {FDP_TBL_LEN, FDP_REV_MAJOR, FDP_REV_MINOR, FDP_BASIC_ID[7:0]};
   localparam logic [31:0] FDP_WORD_PTR =
      {FDP_BASIC_ID[15:8], FDP_TABLE_PTR};
   localparam logic [31:0] FDP_WORD_ERASE =
      {FDP_FILL, FDP_UNUSED1, FDP_SUP_114, FDP_SUP_144, FDP_SUP_122,
       FDP_SUP_DTR, FDP_ADDR_BYTES, FDP_SUP_112, FDP_ERASE4K_INS,
       FDP_UNUSED3, FDP_WREN_SEL, FDP_VOL_BP, FDP_WR_GRAN,
       FDP_ERASE_SIZE};
   localparam logic [31:0] FDP_WORD_QUAD =
      {FDP_INS_114, FDP_MODE_114, FDP_WAIT_114,
       FDP_INS_144, FDP_MODE_144, FDP_WAIT_144};
   localparam logic [31:0] FDP_WORD_DUAL =
      {FDP_INS_122, FDP_MODE_122, FDP_WAIT_122,
       FDP_INS_112, FDP_MODE_112, FDP_WAIT_112};
   localparam logic [31:0] FDP_WORD_BLANK = 32'hffffffff;

   // ----------------------------------------------------------------
   // Reset values and responses
   // ----------------------------------------------------------------
   localparam logic [7:0]  FDP_PTR_RST    = 8'h00;
   localparam logic [1:0]  FDP_RESP_OKAY  = 2'b00;
   localparam logic [1:0]  FDP_RESP_SLV   = 2'b10;
   localparam logic [1:0]  FDP_RESP_DEC   = 2'b11;

   // Stream port read value: beyond-table flag, pointer, data byte
   typedef struct packed {
      logic [14:0] zero;
      logic        beyond;
      logic [7:0]  ptr;
      logic [7:0]  data;
   } fdp_stream_t;

   typedef enum logic [1:0] {
      FDP_WS_IDLE = 2'b00,
      FDP_WS_ADDR = 2'b01,
      FDP_WS_RESP = 2'b11,
      FDP_WS_DATA = 2'b10
   } fdp_wstate_t;

   typedef enum logic {
      FDP_RS_IDLE = 1'b0,
      FDP_RS_RESP = 1'b1
   } fdp_rstate_t;

endpackage

// >>> fdp_param_rom.sv
// Summary of operation
// RULE1 - Mandatory basic header with ID FF00h present
// RULE2 - Revision 1.06, zero extra headers, FFh fill
// RULE3 - Basic header ID low, revision, length 10h
// RULE4 - Table pointer 000030h, ID high FFh
// RULE5 - Erase size, granularity, ones, 4KB erase 20h
// RULE6 - Volatile block protect bit reads zero
// RULE7 - Write enable select bit reads zero
// RULE8 - 1-1-2 supported, address byte code 01b
// RULE9 - DTR clocking support bit set
// RULE10 - 1-2-2 supported, unused bit 23 set
// RULE11 - 1-4-4, 1-1-4 supported, byte 33h FFh
// RULE12 - Density bytes FFh FFh FFh 07h
// RULE13 - 1-4-4 wait count 00100b
// RULE14 - 1-4-4 mode count 010b, instruction EBh
// RULE15 - 1-1-4 wait 01000b, mode 000b, 6Bh
// RULE16 - 1-1-2 wait 01000b, mode 000b, 3Bh
// RULE17 - 1-2-2 wait 00000b, mode 100b, BBh
// RULE18 - Signature bytes 53h 46h 44h 50h
// RULE19 - Sequential byte reads from set address
`timescale 1ns/100ps

module fdp_param_rom
   import fdp_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rstn,
   input  wire logic [FDP_AW-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [FDP_DW-1:0] s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [FDP_AW-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [FDP_DW-1:0]      s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);

   // ----------------------------------------------------------------
   // Parameter table contents
   // ----------------------------------------------------------------
   // Words between the header and the basic table read as erased
   logic [31:0] rom_w [FDP_ROM_WORDS];

   always_comb begin
      for (int i = 0; i < FDP_ROM_WORDS; i++) begin
         rom_w[i] = FDP_WORD_BLANK;
      end
      rom_w[FDP_OFF_SIG[5:2]]   = FDP_WORD_SIG;   // RULE18
      rom_w[FDP_OFF_REV[5:2]]   = FDP_WORD_REV;   // RULE2
      rom_w[FDP_OFF_HDR[5:2]]   = FDP_WORD_HDR;   // RULE1 RULE3
      rom_w[FDP_OFF_PTR[5:2]]   = FDP_WORD_PTR;   // RULE4
      rom_w[FDP_OFF_ERASE[5:2]] = FDP_WORD_ERASE; // RULE5 RULE6 RULE7
      rom_w[FDP_OFF_DENS[5:2]]  = FDP_DENSITY;    // RULE12
      rom_w[FDP_OFF_QUAD[5:2]]  = FDP_WORD_QUAD;  // RULE13 RULE14 RULE15
      rom_w[FDP_OFF_DUAL[5:2]]  = FDP_WORD_DUAL;  // RULE16 RULE17
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   fdp_wstate_t       wst_r;
   fdp_wstate_t       wst_nxt;
   fdp_rstate_t       rst_r;
   fdp_rstate_t       rst_nxt;
   logic [FDP_AW-1:0] awaddr_r;
   logic [FDP_DW-1:0] wdata_r;
   logic [3:0]        wstrb_r;
   logic              awready_r;
   logic              wready_r;
   logic              bvalid_r;
   logic [1:0]        bresp_r;
   logic [1:0]        bresp_nxt;
   logic              arready_r;
   logic              rvalid_r;
   logic [FDP_DW-1:0] rdata_r;
   logic [1:0]        rresp_r;
   logic [7:0]        ptr_r;
   logic [7:0]        ptr_nxt;

   // ----------------------------------------------------------------
   // Handshake decode
   // ----------------------------------------------------------------
   wire               aw_hs    = s_axi_awvalid & awready_r;
   wire               w_hs     = s_axi_wvalid & wready_r;
   wire               b_hs     = bvalid_r & s_axi_bready;
   wire               ar_hs    = s_axi_arvalid & arready_r;
   wire               r_hs     = rvalid_r & s_axi_rready;

   wire [FDP_AW-1:0]  wr_addr  = aw_hs ? s_axi_awaddr : awaddr_r;
   wire [FDP_DW-1:0]  wr_data  = w_hs ? s_axi_wdata : wdata_r;
   wire [3:0]         wr_strb  = w_hs ? s_axi_wstrb : wstrb_r;
   wire               wr_fire  = (wst_nxt == FDP_WS_RESP) &&
                                 (wst_r != FDP_WS_RESP);
   wire               wr_rom   = wr_addr < FDP_OFF_ROM_END;
   wire               wr_sadr  = wr_addr[7:2] == FDP_OFF_STR_ADDR[7:2];
   wire               wr_sdat  = wr_addr[7:2] == FDP_OFF_STR_DATA[7:2];
   wire               ptr_load = wr_fire & wr_sadr & wr_strb[0];

   wire               rd_rom   = s_axi_araddr < FDP_OFF_ROM_END;
   wire               rd_sadr  = s_axi_araddr[7:2] ==
                                 FDP_OFF_STR_ADDR[7:2];
   wire               rd_sdat  = s_axi_araddr[7:2] ==
                                 FDP_OFF_STR_DATA[7:2];
   wire               str_pop  = ar_hs & rd_sdat;

   // ----------------------------------------------------------------
   // Byte stream port
   // ----------------------------------------------------------------
   // Dwords are stored least significant byte first, so byte n of the
   // table sits in lane n[1:0] of word n[5:2]
   wire               ptr_beyond = ptr_r >= FDP_OFF_ROM_END;
   wire [31:0]        ptr_word   = rom_w[ptr_r[5:2]];
   wire [7:0]         ptr_byte   = ptr_beyond ? FDP_FILL :
                                   ptr_word[{ptr_r[1:0], 3'b000} +: 8];
   fdp_stream_t       str_val;

   assign str_val.zero   = '0;
   assign str_val.beyond = ptr_beyond;
   assign str_val.ptr    = ptr_r;
   assign str_val.data   = ptr_byte;

   // A software load of the pointer wins over a pop in the same cycle,
   // so a host restarting a walk never lands one byte late
   assign ptr_nxt = ptr_load ? wr_data[7:0] :
                    str_pop  ? ptr_r + 8'h01 :
                    ptr_r;                          // RULE19

   // ----------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------
   wire [FDP_DW-1:0]  rd_val  = rd_rom  ? rom_w[s_axi_araddr[5:2]] :
                                rd_sadr ? {24'h000000, ptr_r} :
                                rd_sdat ? str_val :
                                32'h00000000;
   wire [1:0]         rd_resp = (rd_rom | rd_sadr | rd_sdat) ?
                                FDP_RESP_OKAY : FDP_RESP_DEC;

   // ----------------------------------------------------------------
   // Write channel control
   // ----------------------------------------------------------------
   always_comb begin
      wst_nxt = wst_r;
      unique case (wst_r)
         FDP_WS_IDLE: begin
            if (aw_hs && w_hs) begin
               wst_nxt = FDP_WS_RESP;
            end else if (aw_hs) begin
               wst_nxt = FDP_WS_ADDR;
            end else if (w_hs) begin
               wst_nxt = FDP_WS_DATA;
            end
         end
         FDP_WS_ADDR: begin
            if (w_hs) begin
               wst_nxt = FDP_WS_RESP;
            end
         end
         FDP_WS_DATA: begin
            if (aw_hs) begin
               wst_nxt = FDP_WS_RESP;
            end
         end
         FDP_WS_RESP: begin
            if (b_hs) begin
               wst_nxt = FDP_WS_IDLE;
            end
         end
      endcase
   end

   // The table is fixed: a write into it is refused, not dropped quietly
   assign bresp_nxt = wr_rom              ? FDP_RESP_SLV :
                      (wr_sadr | wr_sdat) ? FDP_RESP_OKAY :
                      FDP_RESP_DEC;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wst_r     <= FDP_WS_IDLE;
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= FDP_RESP_OKAY;
      end else begin
         wst_r     <= wst_nxt;
         awready_r <= (wst_nxt == FDP_WS_IDLE) || (wst_nxt == FDP_WS_DATA);
         wready_r  <= (wst_nxt == FDP_WS_IDLE) || (wst_nxt == FDP_WS_ADDR);
         bvalid_r  <= wst_nxt == FDP_WS_RESP;
         if (wr_fire) begin
            bresp_r <= bresp_nxt;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         awaddr_r <= '0;
         wdata_r  <= '0;
         wstrb_r  <= '0;
      end else begin
         if (aw_hs) begin
            awaddr_r <= s_axi_awaddr;
         end
         if (w_hs) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read channel control
   // ----------------------------------------------------------------
   always_comb begin
      rst_nxt = rst_r;
      unique case (rst_r)
         FDP_RS_IDLE: begin
            if (ar_hs) begin
               rst_nxt = FDP_RS_RESP;
            end
         end
         FDP_RS_RESP: begin
            if (r_hs) begin
               rst_nxt = FDP_RS_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rst_r     <= FDP_RS_IDLE;
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= '0;
         rresp_r   <= FDP_RESP_OKAY;
         ptr_r     <= FDP_PTR_RST;
      end else begin
         rst_r     <= rst_nxt;
         arready_r <= rst_nxt == FDP_RS_IDLE;
         rvalid_r  <= rst_nxt == FDP_RS_RESP;
         ptr_r     <= ptr_nxt;
         if (ar_hs) begin
            rdata_r <= rd_val;
            rresp_r <= rd_resp;
         end
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_sig_word: // RULE18
      assert property (@(posedge clock) disable iff (!rstn)
         ar_hs && s_axi_araddr[7:2] == 6'h00
         |=> s_axi_rvalid && s_axi_rdata == 32'h50444653)
      else $error("signature word wrong");

   a_rev_word: // RULE2
      assert property (@(posedge clock) disable iff (!rstn)
         ar_hs && s_axi_araddr[7:2] == 6'h01
         |=> s_axi_rdata == 32'hff000106 && s_axi_rresp == 2'b00)
      else $error("revision word wrong");

   a_hdr_word: // RULE3
      assert property (@(posedge clock) disable iff (!rstn)
         ar_hs && s_axi_araddr[7:2] == 6'h02
         |=> s_axi_rdata == 32'h10010600)
      else $error("basic header word wrong");

   a_ptr_word: // RULE4
      assert property (@(posedge clock) disable iff (!rstn)
         ar_hs && s_axi_araddr[7:2] == 6'h03
         |=> s_axi_rdata == 32'hff000030)
      else $error("table pointer word wrong");

   a_erase_word: // RULE5
      assert property (@(posedge clock) disable iff (!rstn)
         ar_hs && s_axi_araddr[7:2] == 6'h0c
         |=> s_axi_rdata == 32'hfffb20e5)
      else $error("erase and support word wrong");

   a_dens_word: // RULE12
      assert property (@(posedge clock) disable iff (!rstn)
         ar_hs && s_axi_araddr[7:2] == 6'h0d
         |=> s_axi_rdata == 32'h07ffffff)
      else $error("density word wrong");

   a_quad_word: // RULE14
      assert property (@(posedge clock) disable iff (!rstn)
         ar_hs && s_axi_araddr[7:2] == 6'h0e
         |=> s_axi_rdata == 32'h6b08eb44)
      else $error("quad read word wrong");

   a_dual_word: // RULE17
      assert property (@(posedge clock) disable iff (!rstn)
         ar_hs && s_axi_araddr[7:2] == 6'h0f
         |=> s_axi_rdata == 32'hbb803b08)
      else $error("dual read word wrong");

   a_stream_step: // RULE19
      assert property (@(posedge clock) disable iff (!rstn)
         str_pop && !ptr_load
         |=> ptr_r == $past(ptr_r) + 8'h01
             && s_axi_rdata[15:8] == $past(ptr_r))
      else $error("stream pointer did not advance");

   a_rdata_hold:
      assert property (@(posedge clock) disable iff (!rstn)
         s_axi_rvalid && !s_axi_rready
         |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped before taken");

   a_wresp_time:
      assert property (@(posedge clock) disable iff (!rstn)
         wr_fire |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
      else $error("write response not raised");

   a_bp_bit: // RULE6
      assert property (@(posedge clock) disable iff (!rstn)
         ar_hs && s_axi_araddr[7:2] == 6'h0c
         |=> !s_axi_rdata[3])
      else $error("block protect bit set");

   a_wren_bit: // RULE7
      assert property (@(posedge clock) disable iff (!rstn)
         ar_hs && s_axi_araddr[7:2] == 6'h0c
         |=> !s_axi_rdata[4])
      else $error("write enable select bit set");

   a_dual_out_cap: // RULE8
      assert property (@(posedge clock) disable iff (!rstn)
         ar_hs && s_axi_araddr[7:2] == 6'h0c
         |=> s_axi_rdata[18:16] == 3'h3)
      else $error("dual output or address bits wrong");

   a_dtr_cap: // RULE9
      assert property (@(posedge clock) disable iff (!rstn)
         ar_hs && s_axi_araddr[7:2] == 6'h0c
         |=> s_axi_rdata[19])
      else $error("double rate bit clear");

   a_dual_io_cap: // RULE10
      assert property (@(posedge clock) disable iff (!rstn)
         ar_hs && s_axi_araddr[7:2] == 6'h0c
         |=> s_axi_rdata[20] && s_axi_rdata[23])
      else $error("dual io or unused bit clear");

   a_quad_caps: // RULE11
      assert property (@(posedge clock) disable iff (!rstn)
         ar_hs && s_axi_araddr[7:2] == 6'h0c
         |=> s_axi_rdata[22:21] == 2'h3 && s_axi_rdata[31:24] == 8'hff)
      else $error("quad support or reserved byte wrong");

   a_quad_out_params: // RULE15
      assert property (@(posedge clock) disable iff (!rstn)
         ar_hs && s_axi_araddr[7:2] == 6'h0e
         |=> s_axi_rdata[31:16] == 16'h6b08)
      else $error("quad output fields wrong");

endmodule

// >>> fdp_host_model.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Bus host that reads the parameter table over AXI4-Lite
// ----------------------------------------------------------------
module fdp_host_model
   import fdp_pkg::*;
(
   input  wire logic              clock,
   output logic [FDP_AW-1:0]      awaddr,
   output logic                   awvalid,
   input  wire logic              awready,
   output logic [FDP_DW-1:0]      wdata,
   output logic [3:0]             wstrb,
   output logic                   wvalid,
   input  wire logic              wready,
   input  wire logic [1:0]        bresp,
   input  wire logic              bvalid,
   output logic                   bready,
   output logic [FDP_AW-1:0]      araddr,
   output logic                   arvalid,
   input  wire logic              arready,
   input  wire logic [FDP_DW-1:0] rdata,
   input  wire logic [1:0]        rresp,
   input  wire logic              rvalid,
   output logic                   rready
);

   // Cycles to hold rready low after the read address is taken
   int rready_lag = 0;

   initial begin
      awaddr  = 8'h00;
      awvalid = 1'b0;
      wdata   = 32'h0;
      wstrb   = 4'h0;
      wvalid  = 1'b0;
      bready  = 1'b0;
      araddr  = 8'h00;
      arvalid = 1'b0;
      rready  = 1'b0;
   end

   // Address and data go out together; each drops once it is taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [1:0] r);
      bit aw_done;
      bit w_done;
      aw_done = 1'b0;
      w_done  = 1'b0;
      @(posedge clock);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= s;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge clock);
         if (!aw_done && awready === 1'b1) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready === 1'b1) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clock); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask

   // One word read: the table is sequential bytes, lowest byte first
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge clock);
      araddr  <= a;
      arvalid <= 1'b1;
      do @(posedge clock); while (arready !== 1'b1);
      arvalid <= 1'b0;
      repeat (rready_lag) @(posedge clock);
      rready  <= 1'b1;
      do @(posedge clock); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

endmodule

// >>> tb_flash_discovery_param_rom.sv
`timescale 1ns/100ps

module tb_flash_discovery_param_rom
   import fdp_pkg::*;
;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] data;
      logic [1:0]  resp;
   } fdp_row_t;

   logic              clock;
   logic              rstn;
   logic [FDP_AW-1:0] awaddr;
   logic              awvalid;
   logic              awready;
   logic [FDP_DW-1:0] wdata;
   logic [3:0]        wstrb;
   logic              wvalid;
   logic              wready;
   logic [1:0]        bresp;
   logic              bvalid;
   logic              bready;
   logic [FDP_AW-1:0] araddr;
   logic              arvalid;
   logic              arready;
   logic [FDP_DW-1:0] rdata;
   logic [1:0]        rresp;
   logic              rvalid;
   logic              rready;
   int                n_fail;
   int                samples_checked;
   int                cycles;
   logic [31:0]       rd;
   logic [1:0]        rs;

   fdp_row_t rows [0:11] = '{
      '{8'h00, 32'h50444653, FDP_RESP_OKAY},
      '{8'h04, 32'hff000106, FDP_RESP_OKAY},
      '{8'h08, 32'h10010600, FDP_RESP_OKAY},
      '{8'h0c, 32'hff000030, FDP_RESP_OKAY},
      '{8'h30, 32'hfffb20e5, FDP_RESP_OKAY},
      '{8'h33, 32'hfffb20e5, FDP_RESP_OKAY},
      '{8'h34, 32'h07ffffff, FDP_RESP_OKAY},
      '{8'h38, 32'h6b08eb44, FDP_RESP_OKAY},
      '{8'h3c, 32'hbb803b08, FDP_RESP_OKAY},
      '{8'h10, 32'hffffffff, FDP_RESP_OKAY},
      '{8'h48, 32'h00000000, FDP_RESP_DEC},
      '{8'hfc, 32'h00000000, FDP_RESP_DEC}
   };

   // Bytes expected from the stream port: from 00h, then from 3eh
   logic [7:0] sx [0:6] = '{8'h53, 8'h46, 8'h44, 8'h50,
                            8'h80, 8'hbb, 8'hff};

   fdp_param_rom i_dut (
      .clock(clock), .rstn(rstn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready)
   );

   fdp_host_model i_host (
      .clock(clock), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready)
   );

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tally_and_finish;
      if (n_fail == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Sets the pointer, then pops n bytes starting at sx[k]
   task automatic stream(input logic [7:0] p, input int k, input int n);
      logic [7:0] q;
      i_host.wr(FDP_OFF_STR_ADDR, {24'h0, p}, 4'h1, rs);
      for (int i = 0; i < n; i++) begin
         q = p + i[7:0];
         i_host.rd(FDP_OFF_STR_DATA, rd, rs);
         chk("stream", {15'h0, q >= 8'h40, q, sx[k+i]}, rd);
      end
   endtask

   // ----------------------------------------------------------------
   // Hang guard
   // ----------------------------------------------------------------
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rstn            = 1'b0;
      n_fail          = 0;
      samples_checked = 0;
      cycles          = 0;
      repeat (5) @(posedge clock);
      chk("arready in reset", 32'h0, {31'h0, arready});
      rstn <= 1'b1;
      i_host.rd(FDP_OFF_STR_ADDR, rd, rs);
      chk("pointer after reset", 32'h0, rd);
      foreach (rows[i]) begin
         i_host.rd(rows[i].addr, rd, rs);
         chk("rdata", rows[i].data, rd);
         chk("rresp", {30'h0, rows[i].resp}, {30'h0, rs});
      end
      // Late rready: the answer must stand until it is taken
      i_host.rready_lag = 3;
      i_host.rd(8'h34, rd, rs);
      i_host.rready_lag = 0;
      chk("rdata late", 32'h07ffffff, rd);
      // Table is read only; a write is refused and leaves it intact
      i_host.wr(8'h30, 32'h0, 4'hf, rs);
      chk("bresp table", {30'h0, FDP_RESP_SLV}, {30'h0, rs});
      i_host.rd(8'h30, rd, rs);
      chk("table after write", 32'hfffb20e5, rd);
      i_host.wr(FDP_OFF_STR_DATA, 32'h0, 4'hf, rs);
      chk("bresp data port", {30'h0, FDP_RESP_OKAY}, {30'h0, rs});
      i_host.wr(8'h50, 32'h0, 4'hf, rs);
      chk("bresp unmapped", {30'h0, FDP_RESP_DEC}, {30'h0, rs});
      // Pointer byte lane disabled: write must not land
      i_host.wr(FDP_OFF_STR_ADDR, 32'h3e, 4'h0, rs);
      i_host.rd(FDP_OFF_STR_ADDR, rd, rs);
      chk("pointer no strobe", 32'h0, rd);
      stream(8'h00, 0, 4);
      stream(8'h3e, 4, 3);
      i_host.rd(FDP_OFF_STR_ADDR, rd, rs);
      chk("pointer advanced", 32'h41, rd);
      // Reset in mid-run clears the pointer and the handshakes
      @(posedge clock);
      rstn <= 1'b0;
      repeat (5) @(posedge clock);
      chk("rvalid in reset", 32'h0, {31'h0, rvalid});
      chk("bvalid in reset", 32'h0, {31'h0, bvalid});
      rstn <= 1'b1;
      i_host.rd(FDP_OFF_STR_ADDR, rd, rs);
      chk("pointer after reset", 32'h0, rd);
      tally_and_finish();
   end

endmodule
